/* shared/fpl_consts.vh */
// Constants for the fast parallel configuration loader
`ifndef FPL_CONSTS_VH
`define FPL_CONSTS_VH
`define FPL_CLK_MHZ 100
`define FPL_T_REQ_LOW_NS 600
`define FPL_T_STAT_MIN_US 268
`define FPL_T_STAT_MAX_US 1506
`define FPL_T_UM_MIN_US 175
`define FPL_T_UM_MAX_US 437
`define FPL_STAT_LOW_CYC (`FPL_T_STAT_MIN_US * `FPL_CLK_MHZ)
`define FPL_UM_CYC (`FPL_T_UM_MIN_US * `FPL_CLK_MHZ)
`define FPL_CU_PERIODS 4
`define FPL_USR_CYC 8576
`define FPL_RATIO_PLAIN 4'h1
`define FPL_RATIO_SEC 4'h4
`define FPL_RATIO_DEC 4'h8
`define FPL_WIDTH_8 2'h0
`define FPL_WIDTH_16 2'h1
`define FPL_WIDTH_32 2'h2
`endif

/* rtl/fpl_sync.v */
// Two-flop synchroniser bank with edge detect on the settled copy
`timescale 1ns/1ps
module fpl_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;
  // First stage is read by the second only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      prev_q <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign sync_out = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

/* rtl/fpl_loader.v */
// Device side of the fast parallel configuration load
`timescale 1ns/1ps
`include "fpl_consts.vh"
module fpl_loader #(
  parameter NWORDS = 32'd1024,
  parameter STAT_CYC = `FPL_STAT_LOW_CYC,
  parameter UM_CYC = `FPL_UM_CYC,
  parameter USR_CYC = `FPL_USR_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire cfg_req_b,
  input wire cfg_clock,
  input wire user_init_clock,
  input wire [31:0] cfg_data,
  input wire [1:0] width_sel,
  input wire decomp_en,
  input wire secure_en,
  input wire use_user_clk,
  input wire status_in,
  output reg status_out_b,
  output reg status_oe_b,
  output reg cfg_complete,
  output reg user_mode,
  output reg [31:0] word_out,
  output reg word_valid,
  output reg [3:0] ratio_out
);
  localparam [5:0] S_RESET = 6'h01;
  localparam [5:0] S_HOLD = 6'h02;
  localparam [5:0] S_WAITREQ = 6'h04;
  localparam [5:0] S_LOAD = 6'h08;
  localparam [5:0] S_INIT = 6'h10;
  localparam [5:0] S_USER = 6'h20;

  wire [2:0] pin_lvl_w;
  wire [2:0] pin_rise_w;
  wire [2:0] pin_fall_w;
  wire req_s;
  wire cfg_clock_r;
  wire uclk_r;
  wire req_fall_w;
  // Request, link clock and user clock pins, two flops each
  fpl_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in({cfg_req_b, cfg_clock, user_init_clock}),
    .sync_out(pin_lvl_w),
    .rise(pin_rise_w),
    .fall(pin_fall_w)
  );
  // Bit order follows the concatenation above
  assign req_s = pin_lvl_w[2];
  assign cfg_clock_r = pin_rise_w[1];
  assign uclk_r = pin_rise_w[0];
  assign req_fall_w = pin_fall_w[2];
  // Status line level seen through the pad; a separate flop pair
  reg st_meta_q;
  reg st_sync_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_meta_q <= 1'b0;
      st_sync_q <= 1'b0;
    end else if (ce) begin
      st_meta_q <= status_in;
      st_sync_q <= st_meta_q;
    end
  end

  // Ratio chosen from the option bits only; decompression wins over security
  reg [3:0] ratio_w;
  always @* begin
    if (decomp_en)
      ratio_w = `FPL_RATIO_DEC;
    else if (secure_en)
      ratio_w = `FPL_RATIO_SEC;
    else
      ratio_w = `FPL_RATIO_PLAIN;
  end

  // Width mask keeps unused upper lines out of the word
  reg [31:0] data_mask_w;
  always @* begin
    case (width_sel)
      `FPL_WIDTH_8: data_mask_w = 32'h0000_00ff;
      `FPL_WIDTH_16: data_mask_w = 32'h0000_ffff;
      default: data_mask_w = 32'hffff_ffff;
    endcase
  end

  // Data sampled twice too, aligned with the synced clock edge
  reg [31:0] d_meta_q;
  reg [31:0] d_sync_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_meta_q <= 32'h0000_0000;
      d_sync_q <= 32'h0000_0000;
    end else if (ce) begin
      d_meta_q <= cfg_data;
      d_sync_q <= d_meta_q;
    end
  end

  reg [5:0] st_q;
  reg [31:0] cnt_q;
  reg [3:0] phase_q;
  reg [31:0] words_q;
  reg [3:0] ratio_q;
  reg [31:0] acc_q;
  // Main sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_RESET;
      cnt_q <= 32'h0000_0000;
      phase_q <= 4'h0;
      words_q <= 32'h0000_0000;
      ratio_q <= `FPL_RATIO_PLAIN;
      acc_q <= 32'h0000_0000;
      status_out_b <= 1'b0;
      status_oe_b <= 1'b0;
      cfg_complete <= 1'b0;
      user_mode <= 1'b0;
      word_out <= 32'h0000_0000;
      word_valid <= 1'b0;
      ratio_out <= `FPL_RATIO_PLAIN;
    end else if (ce) begin
      word_valid <= 1'b0;
      ratio_out <= ratio_q;
      if (req_fall_w || !req_s) begin
        // Few cycles through sync, well under 600 ns
        st_q <= S_HOLD;
        status_out_b <= 1'b0;
        status_oe_b <= 1'b0;
        cfg_complete <= 1'b0;
        user_mode <= 1'b0;
        // Saturates, so a long request never restarts the low count
        if (st_q != S_HOLD)
          cnt_q <= 32'h0000_0000;
        else if (cnt_q < STAT_CYC)
          cnt_q <= cnt_q + 32'h0000_0001;
      end else begin
        case (st_q)
          S_RESET: begin
            st_q <= S_HOLD;
            cnt_q <= 32'h0000_0000;
          end
          S_HOLD: begin
            // Minimum low time, then let go of the pad
            if (cnt_q >= STAT_CYC - 32'h0000_0001) begin
              status_oe_b <= 1'b1;
              status_out_b <= 1'b1;
              st_q <= S_WAITREQ;
            end else
              cnt_q <= cnt_q + 32'h0000_0001;
          end
          S_WAITREQ: begin
            // Someone outside may stretch status low
            if (st_sync_q) begin
              st_q <= S_LOAD;
              ratio_q <= ratio_w;
              phase_q <= 4'h0;
              words_q <= 32'h0000_0000;
            end
          end
          S_LOAD: begin
            if (cfg_clock_r) begin
              if (phase_q == 4'h0)
                acc_q <= d_sync_q & data_mask_w;
              // Extra clocks go to decrypt and expand
              if (phase_q == ratio_q - 4'h1) begin
                phase_q <= 4'h0;
                word_out <= (phase_q == 4'h0) ?
                  (d_sync_q & data_mask_w) : acc_q;
                word_valid <= 1'b1;
                words_q <= words_q + 32'h0000_0001;
                if (words_q == NWORDS - 32'h0000_0001) begin
                  cfg_complete <= 1'b1;
                  st_q <= S_INIT;
                  cnt_q <= 32'h0000_0000;
                end
              end else
                phase_q <= phase_q + 4'h1;
            end
          end
          S_INIT: begin
            if (use_user_clk) begin
              // Count config clocks first, then user clocks
              if (cnt_q < `FPL_CU_PERIODS) begin
                if (cfg_clock_r)
                  cnt_q <= cnt_q + 32'h0000_0001;
              end else if (uclk_r) begin
                if (cnt_q >= USR_CYC + `FPL_CU_PERIODS - 1) begin
                  user_mode <= 1'b1;
                  st_q <= S_USER;
                end else
                  cnt_q <= cnt_q + 32'h0000_0001;
              end
            end else begin
              if (cnt_q >= UM_CYC - 32'h0000_0001) begin
                user_mode <= 1'b1;
                st_q <= S_USER;
              end else
                cnt_q <= cnt_q + 32'h0000_0001;
            end
          end
          S_USER: st_q <= S_USER;
          default: st_q <= S_RESET;
        endcase
      end
    end
  end
endmodule

/* bench/fpl_loader_chk.sv */
// Port assertions for the fast parallel configuration loader
`timescale 1ns/1ps
module fpl_loader_chk #(
  parameter STAT_CYC = 26800,
  parameter UM_CYC = 17500
) (
  input wire clk,
  input wire rst_b,
  input wire cfg_req_b,
  input wire [1:0] width_sel,
  input wire decomp_en,
  input wire secure_en,
  input wire use_user_clk,
  input wire status_out_b,
  input wire status_oe_b,
  input wire cfg_complete,
  input wire user_mode,
  input wire [31:0] word_out,
  input wire word_valid,
  input wire [3:0] ratio_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RATIO: assert property (word_valid |-> ratio_out ==
    (decomp_en ? 4'h8 : secure_en ? 4'h4 : 4'h1)) else $error("bad ratio");
  AST_REQ_FALL: assert property ($fell(cfg_req_b) |-> ##[0:60]
    (!cfg_complete && !status_oe_b && !status_out_b)) else $error("slow");
  // Consecutive low samples of the status enable; saturates at all ones
  logic [31:0] stat_low_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      stat_low_q <= 32'h0000_0000;
    else if (status_oe_b)
      stat_low_q <= 32'h0000_0000;
    else if (stat_low_q != 32'hffff_ffff)
      stat_low_q <= stat_low_q + 32'h0000_0001;
  end
  AST_STAT_MIN: assert property ($rose(status_oe_b) |->
    stat_low_q >= STAT_CYC) else $error("status short");
  // Release window fits the shortened status count only
  AST_STAT_REL: assert property ($rose(cfg_req_b) |->
    ##[1:60] status_oe_b) else $error("status stuck");
  AST_WORD_MASK: assert property (word_valid && width_sel < 2'h2 |->
    (word_out >> (width_sel == 2'h0 ? 8 : 16)) == 0) else $error("mask");
  AST_VALID_PULSE: assert property (word_valid |=> !word_valid)
    else $error("valid long");
  AST_UM_LATE: assert property ($rose(cfg_complete) && !use_user_clk |->
    !user_mode ##[1:45] user_mode) else $error("user mode late");
  AST_UM_EARLY: assert property ($rose(user_mode) && !use_user_clk |->
    $past(cfg_complete, UM_CYC - 1)) else $error("user mode early");
  AST_USR: assert property ($rose(user_mode) && use_user_clk |->
    $past(cfg_complete, 60)) else $error("user clock mode early");
endmodule
bind fpl_loader fpl_loader_chk #(.STAT_CYC(STAT_CYC), .UM_CYC(UM_CYC)) i_chk (
  .clk(clk),
  .rst_b(rst_b),
  .cfg_req_b(cfg_req_b),
  .width_sel(width_sel),
  .decomp_en(decomp_en),
  .secure_en(secure_en),
  .use_user_clk(use_user_clk),
  .status_out_b(status_out_b),
  .status_oe_b(status_oe_b),
  .cfg_complete(cfg_complete),
  .user_mode(user_mode),
  .word_out(word_out),
  .word_valid(word_valid),
  .ratio_out(ratio_out)
);

/* bench/fpl_host_model.sv */
// Configuration host: request pulse, link clock and data words
`timescale 1ns/1ps
module fpl_host_model (
  input wire clk,
  input wire status_line,
  output logic cfg_req_b,
  output logic cfg_clock,
  output logic [31:0] cfg_data
);
  logic [31:0] w [0:3];
  initial begin
    cfg_req_b = 1'b1;
    cfg_clock = 1'b0;
    cfg_data = 32'h0000_0000;
  end
  // Clock parks low between frames; stale data is inverted once per clock period
  task automatic load(input int r, input int n, input bit usr);
    int k;
    cfg_req_b <= 1'b0;
    repeat (200) @(posedge clk);
    cfg_req_b <= 1'b1;
    for (k = 0; k < 300 && !status_line; k++) @(posedge clk);
    repeat (200) @(posedge clk);
    for (k = 0; k < n * r + r - 1 + (usr ? 4 : 0); k++) begin
      cfg_data <= (k / r < n) ? w[k / r] : ~cfg_data;
      repeat (4) @(posedge clk);
      cfg_clock <= 1'b1;
      repeat (4) @(posedge clk);
      cfg_clock <= 1'b0;
    end
    cfg_data <= ~cfg_data;
  endtask
endmodule

/* bench/fast_parallel_config_loader_tb_top.sv */
// Self-checking bench for the fast parallel configuration loader
`timescale 1ns/1ps
module fast_parallel_config_loader_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, dec = 1'b0, sec = 1'b0, usr = 1'b0;
  logic ce = 1'b1;
  logic [1:0] wsel = 2'h2;
  logic [2:0] ucnt = 3'h0;
  wire req_b, cclk, oe_b, out_b, done, um, wv;
  wire [31:0] data, wout;
  wire [3:0] ratio;
  wire line = oe_b ? 1'b1 : out_b; // Open drain with pull-up
  int num_errors = 0, compares = 0, seed = 84, nv, i;
  logic [31:0] exp_q [$];
  always #5 clk = ~clk;
  // User init clock free-runs at 80 ns
  always @(posedge clk) ucnt <= ucnt + 3'h1;
  fpl_host_model i_host (.clk(clk), .status_line(line), .cfg_req_b(req_b),
    .cfg_clock(cclk), .cfg_data(data));
  fpl_loader #(.NWORDS(4), .STAT_CYC(20), .UM_CYC(30), .USR_CYC(8)) i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .cfg_req_b(req_b), .cfg_clock(cclk),
    .user_init_clock(ucnt[2]), .cfg_data(data), .width_sel(wsel),
    .decomp_en(dec), .secure_en(sec), .use_user_clk(usr), .status_in(line),
    .status_out_b(out_b), .status_oe_b(oe_b), .cfg_complete(done),
    .user_mode(um), .word_out(wout), .word_valid(wv), .ratio_out(ratio));
  function automatic logic [3:0] f_ratio(logic d, logic s);
    return d ? 4'h8 : s ? 4'h4 : 4'h1;
  endfunction
  function automatic logic [31:0] f_mask(logic [31:0] v, logic [1:0] ws);
    return ws == 2'h0 ? v & 32'h0000_00ff : ws == 2'h1 ? v & 32'h0000_ffff : v;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Every captured word against the host's order
  always @(posedge clk) if (wv === 1'b1) begin
    nv++;
    chk("word", exp_q.size() ? exp_q.pop_front() : 32'hx, wout);
    chk("ratio", f_ratio(dec, sec), ratio);
  end
  initial begin
    #300000;
    num_errors++;
    report_and_stop;
  end
  // Every option pair, every width, both init clock sources
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) begin
      dec <= i[1];
      sec <= i[0] && i < 4;
      wsel <= i == 4 ? 2'h0 : i == 1 ? 2'h1 : 2'h2;
      usr <= i == 4;
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        i_host.w[k] = k ? $random(seed) : 32'hffff_ffff;
        exp_q.push_back(f_mask(i_host.w[k], wsel));
      end
      nv = 0;
      i_host.load(int'(f_ratio(dec, sec)), 4, usr);
      for (int k = 0; k < 300 && um !== 1'b1; k++) @(posedge clk);
      chk("count", 4, nv);
      chk("done", 1, done);
      chk("user", 1, um);
    end
    // Frozen block must ignore a request until its enable returns
    ce <= 1'b0;
    i_host.cfg_req_b <= 1'b0;
    repeat (20) @(posedge clk);
    chk("frozen", 1, done);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    chk("abort", 0, done);
    i_host.cfg_req_b <= 1'b1;
    repeat (40) @(posedge clk);
    chk("status", 1, line);
    report_and_stop;
  end
endmodule
